// >>> hdl/lsbu_defines.svh
// constants for the logic, shift and bit operation unit
`ifndef LSBU_DEFINES_SVH
`define LSBU_DEFINES_SVH
`define LSBU_DATA_W 32
`define LSBU_BYTE_MSB 7
`define LSBU_WORD_MSB 15
`define LSBU_LONG_MSB 31
`define LSBU_BITNO_W 3
`define LSBU_RESET_DATA 32'h0000_0000
`endif

// >>> hdl/lsbu_pkg.sv
// types for the logic, shift and bit operation unit
package lsbu_pkg;
  typedef enum logic [1:0] {
    LSBU_SZ_BYTE = 2'h0,
    LSBU_SZ_WORD = 2'h1,
    LSBU_SZ_LONG = 2'h2
  } lsbu_size_t;
  typedef enum logic [4:0] {
    LSBU_OP_AND = 5'h00,
    LSBU_OP_OR = 5'h01,
    LSBU_OP_XOR = 5'h02,
    LSBU_OP_NOT = 5'h03,
    LSBU_OP_ASHL = 5'h04,
    LSBU_OP_ASHR = 5'h05,
    LSBU_OP_LSHL = 5'h06,
    LSBU_OP_LSHR = 5'h07,
    LSBU_OP_ROTATE_LEFT = 5'h08,
    LSBU_OP_ROTATE_RIGHT = 5'h09,
    LSBU_OP_ROTCL = 5'h0a,
    LSBU_OP_ROTCR = 5'h0b,
    LSBU_OP_BIT_SET_OP = 5'h0c,
    LSBU_OP_BIT_CLEAR_OP = 5'h0d,
    LSBU_OP_BINV = 5'h0e,
    LSBU_OP_BIT_TEST_OP = 5'h0f,
    LSBU_OP_CAND = 5'h10,
    LSBU_OP_CANDI = 5'h11,
    LSBU_OP_COR = 5'h12,
    LSBU_OP_CORI = 5'h13,
    LSBU_OP_CXOR = 5'h14,
    LSBU_OP_CXORI = 5'h15,
    LSBU_OP_BLD = 5'h16,
    LSBU_OP_BLDI = 5'h17,
    LSBU_OP_BST = 5'h18,
    LSBU_OP_BSTI = 5'h19
  } lsbu_op_t;
  // one request from the decoder
  typedef struct packed {
    lsbu_op_t op;
    lsbu_size_t size;
    logic use_imm;     // second operand / bit number from immediate
    logic two_places;  // shift or rotate by two instead of one
    logic [31:0] dst;
    logic [31:0] src_gpr;
    logic [31:0] imm;
    logic [2:0] bit_imm;
  } lsbu_req_t;
  // condition flags handed back
  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } lsbu_flags_t;
endpackage : lsbu_pkg

// >>> hdl/lsbu_unit.sv
// logic, shift/rotate and single-bit datapath, one result per request
// interface and timing
// - the unit has one clock; every output comes from a flip-flop
// - a request is taken on any rising edge with REQ_VALID high
// - RES_VALID follows one edge later and stands for one cycle
// - RES_DATA, RES_WRITE and FLAGS_OUT hold until the next request
// - requests may come back to back, one per cycle, in any order
// - nothing is refused; an unknown op code hands dst back untouched,
//   with RES_WRITE low and the flags passed through
//
// operand handling
// - logic and shift results are trimmed to the selected size, so the
//   bits above it come back as zero; the register file merges the
//   narrow result with the untouched upper part of the register
// - bit operations look only at the low byte of dst; the upper three
//   bytes are handed back as they came
// - memory operands arrive in dst from the access path; this unit
//   never talks to memory itself
//
// flags
// - logic ops: n and z from the result, v cleared, c kept
// - shifts and rotates: n and z from the result, v cleared, c takes
//   the last bit shifted or rotated out
// - arithmetic left shift behaves as the logical one; overflow is
//   not detected, so v always reads zero after it
// - bit test writes only z; carry ops and bit loads write only c
// - bit set, clear, invert and store leave all flags as they were
// - v passes through unchanged for every bit operation
//
// shifts by two places
// - the second place reuses the one-place step on the first result,
//   so fill, width and carry rules cannot drift apart
// - rotate through carry by two is a ring of width plus one bits;
//   the carry out of the first step feeds the second
// - the price is two step units in series on the longest path,
//   traded for a single, simple step description
//
// bit numbers
// - the inverted carry ops, inverted load and inverted store always
//   take the immediate bit number, whatever use_imm says
// - every other bit op takes the immediate when use_imm is set, else
//   the low three bits of src_gpr
// - bit numbers from src_gpr ignore its upper bits on purpose
//
// reset
// - reset clears every output at once, without waiting for the clock
// - during reset RES_DATA, RES_WRITE and FLAGS_OUT all read zero
// - a request may be made on the first edge after release
//
// limitations
// - no arithmetic, branch or system operations live here
// - there is no queue; each request gives exactly one result
// - the flags in FLAGS_IN are taken with the request, so a flag
//   update still in flight elsewhere must be forwarded by the caller
// - the result registers load only on a request and then hold, so a
//   stale value stays visible; consumers qualify it with RES_VALID
// - the unit keeps no flag state of its own; FLAGS_OUT is only the
//   proposal for the condition register, written by the caller
`timescale 1ns/100ps
`default_nettype none
`include "lsbu_defines.svh"
module lsbu_unit (
  input wire logic CLK_SYS,              // core clock, 20 MHz
  input wire logic NRST,                 // async reset, active low
  input wire logic REQ_VALID,            // one-cycle request strobe
  input wire lsbu_pkg::lsbu_req_t REQ,   // operation and operands
  input wire lsbu_pkg::lsbu_flags_t FLAGS_IN, // current flags
  output logic RES_VALID,                // result strobe, one cycle
  output logic [31:0] RES_DATA,          // result for write back
  output logic RES_WRITE,                // result must be written back
  output lsbu_pkg::lsbu_flags_t FLAGS_OUT // updated flags
);
  import lsbu_pkg::*;

  // width mask for the selected operand size
  function automatic logic [31:0] size_mask(input lsbu_size_t sz);
    case (sz)
      LSBU_SZ_BYTE: size_mask = 32'h0000_00ff;
      LSBU_SZ_WORD: size_mask = 32'h0000_ffff;
      default: size_mask = 32'hffff_ffff;
    endcase
  endfunction : size_mask

  // index of the sign bit for the selected operand size
  function automatic logic [4:0] msb_index(input lsbu_size_t sz);
    case (sz)
      LSBU_SZ_BYTE: msb_index = 5'(`LSBU_BYTE_MSB);
      LSBU_SZ_WORD: msb_index = 5'(`LSBU_WORD_MSB);
      default: msb_index = 5'(`LSBU_LONG_MSB);
    endcase
  endfunction : msb_index

  // one place of shift or rotate inside the operand width; returns
  // {carry_out, data}. bits above the width are kept zero.
  function automatic logic [32:0] step1(input lsbu_op_t op,
                                        input lsbu_size_t sz,
                                        input logic [31:0] d,
                                        input logic cin);
    logic [4:0] m;
    logic [31:0] mk;
    logic top;
    logic [31:0] r;
    logic co;
    m = msb_index(sz);
    mk = size_mask(sz);
    top = d[m];
    r = 32'h0000_0000;
    co = 1'b0;
    case (op)
      LSBU_OP_ASHL, LSBU_OP_LSHL: begin
        r = (d << 1) & mk;
        co = top;
      end
      LSBU_OP_ASHR: begin
        r = (d >> 1) | ({31'h0, top} << m);
        co = d[0];
      end
      LSBU_OP_LSHR: begin
        r = d >> 1;
        co = d[0];
      end
      LSBU_OP_ROTATE_LEFT: begin
        r = ((d << 1) & mk) | {31'h0, top};
        co = top;
      end
      LSBU_OP_ROTATE_RIGHT: begin
        r = (d >> 1) | ({31'h0, d[0]} << m);
        co = d[0];
      end
      LSBU_OP_ROTCL: begin
        r = ((d << 1) & mk) | {31'h0, cin};
        co = top;
      end
      LSBU_OP_ROTCR: begin
        r = (d >> 1) | ({31'h0, cin} << m);
        co = d[0];
      end
      default: begin
        r = d;
        co = cin;
      end
    endcase
    step1 = {co, r};
  endfunction : step1

  logic [31:0] mask;
  logic [31:0] dst_m;
  logic [31:0] src_m;
  logic [2:0] bit_no;
  logic [7:0] bit_sel;
  logic [7:0] byte_in;
  logic cur_bit;
  logic [32:0] sh_a;
  logic [32:0] sh_b;
  logic [31:0] res_d;
  logic wr_d;
  lsbu_flags_t flg_d;
  logic [31:0] res_data_q;
  logic res_write_q;
  logic res_valid_q;
  lsbu_flags_t flags_q;

  // operand trimming; bit operations only ever see the low byte
  assign mask = size_mask(REQ.size);
  assign dst_m = REQ.dst & mask;
  assign src_m = (REQ.use_imm ? REQ.imm : REQ.src_gpr) & mask;
  assign byte_in = REQ.dst[7:0];
  // inverted variants always take the immediate bit number
  always_comb begin
    case (REQ.op)
      LSBU_OP_CANDI, LSBU_OP_CORI, LSBU_OP_CXORI, LSBU_OP_BLDI,
      LSBU_OP_BSTI: bit_no = REQ.bit_imm;
      default: bit_no = REQ.use_imm ? REQ.bit_imm
                                    : REQ.src_gpr[2:0];
    endcase
  end
  assign bit_sel = 8'h01 << bit_no;
  assign cur_bit = byte_in[bit_no];

  // the second place reuses the first step so width and fill rules match
  assign sh_a = step1(REQ.op, REQ.size, dst_m, FLAGS_IN.c);
  assign sh_b = step1(REQ.op, REQ.size, sh_a[31:0], sh_a[32]);

  // result and flag selection; flags not touched pass through
  always_comb begin
    res_d = REQ.dst;
    wr_d = 1'b0;
    flg_d = FLAGS_IN;
    case (REQ.op)
      LSBU_OP_AND, LSBU_OP_OR, LSBU_OP_XOR, LSBU_OP_NOT: begin
        case (REQ.op)
          LSBU_OP_AND: res_d = dst_m & src_m;
          LSBU_OP_OR: res_d = dst_m | src_m;
          LSBU_OP_XOR: res_d = dst_m ^ src_m;
          default: res_d = ~dst_m & mask;
        endcase
        wr_d = 1'b1;
        flg_d.n = res_d[msb_index(REQ.size)];
        flg_d.z = (res_d == 32'h0000_0000);
        flg_d.v = 1'b0;
      end
      LSBU_OP_ASHL, LSBU_OP_ASHR, LSBU_OP_LSHL, LSBU_OP_LSHR,
      LSBU_OP_ROTATE_LEFT, LSBU_OP_ROTATE_RIGHT, LSBU_OP_ROTCL, LSBU_OP_ROTCR: begin
        res_d = REQ.two_places ? sh_b[31:0] : sh_a[31:0];
        flg_d.c = REQ.two_places ? sh_b[32] : sh_a[32];
        wr_d = 1'b1;
        flg_d.n = res_d[msb_index(REQ.size)];
        flg_d.z = (res_d == 32'h0000_0000);
        flg_d.v = 1'b0;
      end
      // upper bytes of the destination are handed back untouched
      LSBU_OP_BIT_SET_OP: begin
        res_d = {REQ.dst[31:8], byte_in | bit_sel};
        wr_d = 1'b1;
      end
      LSBU_OP_BIT_CLEAR_OP: begin
        res_d = {REQ.dst[31:8], byte_in & ~bit_sel};
        wr_d = 1'b1;
      end
      LSBU_OP_BINV: begin
        res_d = {REQ.dst[31:8], byte_in ^ bit_sel};
        wr_d = 1'b1;
      end
      LSBU_OP_BIT_TEST_OP: flg_d.z = ~cur_bit;
      LSBU_OP_CAND: flg_d.c = FLAGS_IN.c & cur_bit;
      LSBU_OP_COR: flg_d.c = FLAGS_IN.c | cur_bit;
      LSBU_OP_CXOR: flg_d.c = FLAGS_IN.c ^ cur_bit;
      LSBU_OP_CANDI: flg_d.c = FLAGS_IN.c & ~cur_bit;
      LSBU_OP_CORI: flg_d.c = FLAGS_IN.c | ~cur_bit;
      LSBU_OP_CXORI: flg_d.c = FLAGS_IN.c ^ ~cur_bit;
      LSBU_OP_BLD: flg_d.c = cur_bit;
      LSBU_OP_BLDI: flg_d.c = ~cur_bit;
      LSBU_OP_BST: begin
        res_d = {REQ.dst[31:8],
                 (byte_in & ~bit_sel) | (FLAGS_IN.c ? bit_sel : 8'h00)};
        wr_d = 1'b1;
      end
      LSBU_OP_BSTI: begin
        res_d = {REQ.dst[31:8],
                 (byte_in & ~bit_sel) | (FLAGS_IN.c ? 8'h00 : bit_sel)};
        wr_d = 1'b1;
      end
      default: begin
        res_d = REQ.dst;
        wr_d = 1'b0;
      end
    endcase
  end

  // result registers; data only loads on a request so it holds otherwise
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      res_data_q <= `LSBU_RESET_DATA;
      flags_q <= '0;
      res_write_q <= 1'b0;
    end else if (REQ_VALID) begin
      res_data_q <= res_d;
      flags_q <= flg_d;
      res_write_q <= wr_d;
    end
  end

  // strobe follows the request by exactly one edge
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      res_valid_q <= 1'b0;
    end else begin
      res_valid_q <= REQ_VALID;
    end
  end

  assign RES_VALID = res_valid_q;
  assign RES_DATA = res_data_q;
  assign RES_WRITE = res_write_q;
  assign FLAGS_OUT = flags_q;
endmodule : lsbu_unit
`default_nettype wire

// >>> tb/lsbu_props.sv
// checker for the logic, shift and bit unit
`timescale 1ns/100ps
`default_nettype none
module lsbu_props (
  input wire logic CLK_SYS, // core clock
  input wire logic NRST, // async reset, low
  input wire logic REQ_VALID, // request strobe
  input wire lsbu_pkg::lsbu_req_t REQ, // request
  input wire lsbu_pkg::lsbu_flags_t FLAGS_IN, // flags in
  input wire logic RES_VALID, // result strobe
  input wire logic [31:0] RES_DATA, // result
  input wire logic RES_WRITE, // write back
  input wire lsbu_pkg::lsbu_flags_t FLAGS_OUT // flags out
);
  import lsbu_pkg::*;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);
  // operand, bit number and selected bits as the rules define them
  wire logic lng = REQ_VALID && REQ.size == LSBU_SZ_LONG;
  wire logic [31:0] opnd = REQ.use_imm ? REQ.imm : REQ.src_gpr;
  wire logic [2:0] bn = REQ.use_imm ? REQ.bit_imm : REQ.src_gpr[2:0];
  wire logic tbit = REQ.dst[bn];
  wire logic ibit = REQ.dst[REQ.bit_imm];
  wire logic [7:0] setb = REQ.dst[7:0] | (8'h01 << bn);
  answer_lat_a: assert property (REQ_VALID |=> RES_VALID)
    else $error("no result one cycle after request");
  quiet_hold_a: assert property (!REQ_VALID |=>
    !RES_VALID && $stable(RES_DATA))
    else $error("result changed without request");
  and_long_a: assert property (lng && REQ.op == LSBU_OP_AND |=>
    RES_DATA == ($past(REQ.dst) & $past(opnd))) else $error("and wrong");
  or_long_a: assert property (lng && REQ.op == LSBU_OP_OR |=>
    RES_DATA == ($past(REQ.dst) | $past(opnd))) else $error("or wrong");
  xor_long_a: assert property (lng && REQ.op == LSBU_OP_XOR |=>
    RES_DATA == ($past(REQ.dst) ^ $past(opnd))) else $error("xor wrong");
  not_long_a: assert property (lng && REQ.op == LSBU_OP_NOT |=>
    RES_WRITE && RES_DATA == ~$past(REQ.dst)) else $error("not wrong");
  bit_set_a: assert property (REQ_VALID && REQ.op == LSBU_OP_BIT_SET_OP |=>
    RES_DATA[7:0] == $past(setb)) else $error("bit set wrong");
  bit_test_a: assert property (REQ_VALID &&
    REQ.op == LSBU_OP_BIT_TEST_OP |=>
    !RES_WRITE && FLAGS_OUT.z == !$past(tbit)) else $error("test wrong");
  inv_load_a: assert property (REQ_VALID &&
    REQ.op == LSBU_OP_BLDI |=>
    FLAGS_OUT.c == !$past(ibit)) else $error("inverted load wrong");
  two_place_c: cover property (REQ_VALID && REQ.two_places);
  inv_store_c: cover property (REQ_VALID && REQ.op == LSBU_OP_BSTI);
  no_write_c: cover property (RES_VALID && !RES_WRITE);
endmodule : lsbu_props
bind lsbu_unit lsbu_props u_props (.CLK_SYS(CLK_SYS), .NRST(NRST),
  .REQ_VALID(REQ_VALID), .REQ(REQ), .FLAGS_IN(FLAGS_IN),
  .RES_VALID(RES_VALID), .RES_DATA(RES_DATA), .RES_WRITE(RES_WRITE),
  .FLAGS_OUT(FLAGS_OUT));
`default_nettype wire

// >>> tb/tb_lsbu_unit.sv
// self-checking bench for the logic, shift and bit unit
`timescale 1ns/100ps
`default_nettype none
module tb_lsbu_unit;
  import lsbu_pkg::*;
  logic CLK_SYS, NRST, REQ_VALID, RES_VALID, RES_WRITE;
  logic [31:0] RES_DATA;
  lsbu_req_t REQ, ex;
  lsbu_flags_t FLAGS_IN, FLAGS_OUT, fin;
  int failures = 0;
  int n_tests = 0;
  lsbu_unit dut (.CLK_SYS(CLK_SYS), .NRST(NRST), .REQ_VALID(REQ_VALID),
    .REQ(REQ), .FLAGS_IN(FLAGS_IN), .RES_VALID(RES_VALID),
    .RES_DATA(RES_DATA), .RES_WRITE(RES_WRITE), .FLAGS_OUT(FLAGS_OUT));
  // 20 MHz clock
  initial begin
    CLK_SYS = 1'b0;
    forever #25 CLK_SYS = ~CLK_SYS;
  end
  // compares for data words and for flag or strobe nibbles
  task automatic chk_data(logic [31:0] got, logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_data
  task automatic chk_nib(logic [3:0] got, logic [3:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_nib
  // one request with extras from ex and fin; answer read mid-cycle
  task automatic go(lsbu_op_t op, lsbu_size_t sz, logic [31:0] d,
                    logic [31:0] ed, logic w, logic [3:0] ef);
    @(posedge CLK_SYS);
    ex.op = op;
    ex.size = sz;
    ex.dst = d;
    REQ <= ex;
    FLAGS_IN <= fin;
    REQ_VALID <= 1'b1;
    @(posedge CLK_SYS);
    REQ_VALID <= 1'b0;
    @(negedge CLK_SYS);
    chk_nib({RES_VALID, RES_WRITE, 2'h0}, {1'b1, w, 2'h0});
    chk_data(RES_DATA, ed);
    chk_nib(FLAGS_OUT, ef);
  endtask : go
  // logic ops at all widths; carry must survive, v is cleared
  task automatic sc_logic();
    ex = '0;
    ex.src_gpr = 32'h0ff0_f00f;
    ex.imm = 32'h0000_ff00;
    fin = 4'h1;
    go(LSBU_OP_AND, LSBU_SZ_LONG, 32'hf0f0_8f81,
       32'h00f0_8001, 1, 4'h1);
    go(LSBU_OP_AND, LSBU_SZ_BYTE, 32'hf0f0_8f81,
       32'h0000_0001, 1, 4'h1);
    go(LSBU_OP_NOT, LSBU_SZ_WORD, 32'hf0f0_8f81,
       32'h0000_707e, 1, 4'h1);
    go(LSBU_OP_NOT, LSBU_SZ_LONG, 32'hf0f0_8f81,
       32'h0f0f_707e, 1, 4'h1);
    ex.use_imm = 1'b1;
    go(LSBU_OP_OR, LSBU_SZ_LONG, 32'hf0f0_8f81,
       32'hf0f0_ff81, 1, 4'h9);
    go(LSBU_OP_XOR, LSBU_SZ_LONG, 32'hf0f0_8f81,
       32'hf0f0_7081, 1, 4'h9);
    go(LSBU_OP_XOR, LSBU_SZ_WORD, 32'hf0f0_8f81,
       32'h0000_7081, 1, 4'h1);
    go(LSBU_OP_AND, LSBU_SZ_BYTE, 32'hf0f0_8f81,
       32'h0000_0000, 1, 4'h5);
    // stale z and v coming in must be replaced, carry kept
    fin = 4'h7;
    go(LSBU_OP_AND, LSBU_SZ_LONG, 32'hf0f0_8f81,
       32'h0000_8f00, 1, 4'h1);
  endtask : sc_logic
  // shifts and rotates; carry takes the last bit out
  task automatic sc_shift();
    ex = '0;
    fin = 4'h0;
    go(LSBU_OP_LSHR, LSBU_SZ_BYTE, 32'haaaa_aa81,
       32'h0000_0040, 1, 4'h1);
    go(LSBU_OP_LSHL, LSBU_SZ_BYTE, 32'h0000_0080,
       32'h0000_0000, 1, 4'h5);
    go(LSBU_OP_ROTATE_LEFT, LSBU_SZ_WORD, 32'h0000_8001,
       32'h0000_0003, 1, 4'h1);
    go(LSBU_OP_ROTCR, LSBU_SZ_BYTE, 32'h0000_0001,
       32'h0000_0000, 1, 4'h5);
    ex.two_places = 1'b1;
    go(LSBU_OP_ASHR, LSBU_SZ_WORD, 32'h0000_8005,
       32'h0000_e001, 1, 4'h8);
    go(LSBU_OP_ASHL, LSBU_SZ_LONG, 32'h6000_0001,
       32'h8000_0004, 1, 4'h9);
    go(LSBU_OP_ROTATE_RIGHT, LSBU_SZ_LONG, 32'h0000_0006,
       32'h8000_0001, 1, 4'h9);
    fin = 4'h1;
    go(LSBU_OP_ROTCL, LSBU_SZ_BYTE, 32'h0000_0040,
       32'h0000_0002, 1, 4'h1);
  endtask : sc_shift
  // bit modify on the low byte; register bit number is 2, immediate 7
  task automatic sc_bits();
    ex = '0;
    ex.src_gpr = 32'h0000_0002;
    ex.bit_imm = 3'h7;
    fin = 4'h1;
    go(LSBU_OP_BIT_SET_OP, LSBU_SZ_BYTE, 32'h1234_5600,
       32'h1234_5604, 1, 4'h1);
    go(LSBU_OP_BIT_CLEAR_OP, LSBU_SZ_BYTE, 32'h1234_56ff,
       32'h1234_56fb, 1, 4'h1);
    go(LSBU_OP_BINV, LSBU_SZ_BYTE, 32'h1234_5610,
       32'h1234_5614, 1, 4'h1);
    go(LSBU_OP_BST, LSBU_SZ_BYTE, 32'h1234_5600,
       32'h1234_5604, 1, 4'h1);
    go(LSBU_OP_BSTI, LSBU_SZ_BYTE, 32'h1234_56ff,
       32'h1234_567f, 1, 4'h1);
    ex.use_imm = 1'b1;
    go(LSBU_OP_BIT_SET_OP, LSBU_SZ_BYTE, 32'h1234_5600,
       32'h1234_5680, 1, 4'h1);
  endtask : sc_bits
  // reset in mid-run clears every output at once; work then resumes
  task automatic sc_reset();
    @(posedge CLK_SYS);
    NRST <= 1'b0;
    @(negedge CLK_SYS);
    chk_nib({RES_VALID, RES_WRITE, 2'h0}, 4'h0);
    chk_data(RES_DATA, 32'h0000_0000);
    chk_nib(FLAGS_OUT, 4'h0);
    repeat (2) @(posedge CLK_SYS);
    NRST <= 1'b1;
    @(negedge CLK_SYS);
    chk_nib({RES_VALID, RES_WRITE, 2'h0}, 4'h0);
    chk_data(RES_DATA, 32'h0000_0000);
    chk_nib(FLAGS_OUT, 4'h0);
  endtask : sc_reset
  // carry ops: register bit 4 is 0, immediate bit 5 is 1
  task automatic sc_carry();
    ex = '0;
    ex.src_gpr = 32'h0000_0004;
    ex.bit_imm = 3'h5;
    fin = 4'h1;
    go(LSBU_OP_BIT_TEST_OP, LSBU_SZ_BYTE, 32'hcafe_0020,
       32'hcafe_0020, 0, 4'h5);
    go(LSBU_OP_CAND, LSBU_SZ_BYTE, 32'hcafe_0020,
       32'hcafe_0020, 0, 4'h0);
    go(LSBU_OP_CANDI, LSBU_SZ_BYTE, 32'hcafe_0020,
       32'hcafe_0020, 0, 4'h0);
    go(LSBU_OP_CXOR, LSBU_SZ_BYTE, 32'hcafe_0020,
       32'hcafe_0020, 0, 4'h1);
    go(LSBU_OP_CXORI, LSBU_SZ_BYTE, 32'hcafe_0020,
       32'hcafe_0020, 0, 4'h1);
    go(LSBU_OP_BLD, LSBU_SZ_BYTE, 32'hcafe_0020,
       32'hcafe_0020, 0, 4'h0);
    go(LSBU_OP_BLDI, LSBU_SZ_BYTE, 32'hcafe_0020,
       32'hcafe_0020, 0, 4'h0);
    go(lsbu_op_t'(5'h1f), LSBU_SZ_BYTE, 32'hcafe_0020,
       32'hcafe_0020, 0, 4'h1);
    fin = 4'h0;
    go(LSBU_OP_COR, LSBU_SZ_BYTE, 32'hcafe_0020,
       32'hcafe_0020, 0, 4'h0);
    go(LSBU_OP_CORI, LSBU_SZ_BYTE, 32'hcafe_0020,
       32'hcafe_0020, 0, 4'h0);
    ex.use_imm = 1'b1;
    go(LSBU_OP_COR, LSBU_SZ_BYTE, 32'hcafe_0020,
       32'hcafe_0020, 0, 4'h1);
    // n, z and v coming in must pass a carry op untouched
    fin = 4'he;
    go(LSBU_OP_CXOR, LSBU_SZ_BYTE, 32'hcafe_0020,
       32'hcafe_0020, 0, 4'hf);
  endtask : sc_carry
  // print counts and verdict, then stop
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop
  // main sequence after three cycles of reset
  initial begin
    NRST = 1'b0;
    REQ_VALID = 1'b0;
    REQ = '0;
    FLAGS_IN = '0;
    repeat (3) @(posedge CLK_SYS);
    NRST <= 1'b1;
    sc_logic();
    sc_shift();
    sc_bits();
    sc_reset();
    sc_carry();
    report_and_stop();
  end
  // watchdog well beyond the roughly 80 cycles the run needs
  initial begin
    #50000;
    failures++;
    report_and_stop();
  end
endmodule : tb_lsbu_unit
`default_nettype wire
